// File: include/uif_pkg.sv
`default_nettype none
package uif_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_IER = 3'h1;
    localparam logic [2:0] OFF_IIR = 3'h2;
    localparam logic [2:0] OFF_FCR = 3'h2;
    localparam logic [2:0] OFF_LCR = 3'h3;
    localparam logic [2:0] OFF_LSR = 3'h5;
    localparam logic [2:0] OFF_MSR = 3'h6;
    // Enable register field positions
    localparam int IER_RDA = 0;
    localparam int IER_THE = 1;
    localparam int IER_RLS = 2;
    localparam int IER_MS = 3;
    // Other field positions
    localparam int FCR_EN = 0;
    localparam int LCR_DLAB = 7;
    localparam int LSR_THE = 5;
    localparam int IIR_VAR = 6;
    localparam int IIR_FEN = 7;
    // Reset values
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;
    // Identification codes: no-interrupt code, then causes highest priority first
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_RLS = 4'h6;
    localparam logic [3:0] ID_RDA = 4'h4;
    localparam logic [3:0] ID_THE = 4'h2;
    localparam logic [3:0] ID_MS = 4'h0;
    // Write-to-interrupt delay in baud ticks (16..48 window)
    localparam int SI_MIN_TICKS = 16;
    localparam int SI_MAX_TICKS = 48;
    localparam logic [5:0] SI_DELAY = 6'h20;
    localparam int BUF_DEPTH = 2;

    // Transmit word, data byte only
    typedef struct packed {
        logic [7:0] data;
    } uif_word_type;

    // Pending interrupt causes
    typedef struct packed {
        logic rls;
        logic rda;
        logic the;
        logic ms;
    } uif_cause_type;
endpackage
`default_nettype wire

// File: rtl/uif_buf.sv
`timescale 1ns/100ps
`default_nettype none
module uif_buf #(
    parameter int WIDTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    wire push = in_valid_i && (cnt_q != 2'h2);
    wire pop = out_ready_i && (cnt_q != 2'h0);

    // Flags and head word
    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rp_q];

    // Two-entry storage with pointers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data_i;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// File: rtl/uif_core.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - On CMOS builds the baud generator stays stopped after reset until divisors are written.
// - On CMOS builds the first transmit write raises the transmit interrupt 16 to 48 ticks later.
// - Identification bit 7 reads one whenever the FIFOs are enabled.
// - Identification bit 6 reads one with FIFOs on in the corrected variant, else always zero.
// - Setting FIFO control bit 0 enables FIFO mode and sets identification bit 7, and bit 6 in the corrected variant.
// - The interrupt output is a level that stays high while any enabled cause is pending.
// - Writing zero to the enable register drops the output; re-enabling raises it again.
// - Four causes exist: line status, receive data, transmit empty, modem status, each gated by its own enable bit.
// - Line status and receive data outrank transmit empty in the identification.
// - Setting the transmit enable raises the transmit interrupt only if the holding register is empty.
// - Reading the identification register while it reports transmit empty clears that indication.
module uif_core #(
    parameter bit CMOS = 1'b1,
    parameter bit FIFO_FIXED = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic line_err_i,
    input wire logic rx_avail_i,
    input wire logic modem_chg_i,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic baud_tick_o,
    output logic interrupt_out_o
);
    logic [7:0] ier_q;
    logic [7:0] lcr_q;
    logic [15:0] div_q;
    logic [15:0] bcnt_q;
    logic brun_q;
    logic fifo_en_q;
    logic the_int_q;
    logic si_arm_q;
    logic [5:0] si_cnt_q;
    logic first_wr_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic tick_q;
    logic [1:0] err_s_q;
    logic [1:0] rx_s_q;
    logic [1:0] ms_s_q;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [7:0] buf_out_data;
    uif_pkg::uif_word_type wr_word;
    uif_pkg::uif_cause_type cause;

    // Decode of register port
    wire dlab = lcr_q[uif_pkg::LCR_DLAB];
    wire wr_data = wr_i && (addr_i == uif_pkg::OFF_DATA) && !dlab;
    wire wr_dll = wr_i && (addr_i == uif_pkg::OFF_DATA) && dlab;
    wire wr_dlm = wr_i && (addr_i == uif_pkg::OFF_IER) && dlab;
    wire wr_ier = wr_i && (addr_i == uif_pkg::OFF_IER) && !dlab;
    wire wr_fcr = wr_i && (addr_i == uif_pkg::OFF_FCR);
    wire wr_lcr = wr_i && (addr_i == uif_pkg::OFF_LCR);
    wire rd_iir = rd_i && (addr_i == uif_pkg::OFF_IIR);
    wire hold_empty = buf_in_ready && !buf_out_valid;
    wire new_tx_interrupt_enable_bit = wdata_i[uif_pkg::IER_THE];
    assign wr_word.data = wdata_i;

    // Pending causes gated by enables
    assign cause.rls = err_s_q[1] && ier_q[uif_pkg::IER_RLS];
    assign cause.rda = rx_s_q[1] && ier_q[uif_pkg::IER_RDA];
    assign cause.the = the_int_q && ier_q[uif_pkg::IER_THE];
    assign cause.ms = ms_s_q[1] && ier_q[uif_pkg::IER_MS];
    wire any_int = |cause; // Level, no pulse per cause

    // Priority encode of identification code
    wire [3:0] id_code = cause.rls ? uif_pkg::ID_RLS :
                         cause.rda ? uif_pkg::ID_RDA :
                         cause.the ? uif_pkg::ID_THE :
                         cause.ms ? uif_pkg::ID_MS : uif_pkg::ID_NONE;
    wire fen_bit = fifo_en_q;
    wire var_bit = fifo_en_q && FIFO_FIXED;
    wire [7:0] iir_val = {fen_bit, var_bit, 2'b00, id_code};

    // Read data selection
    wire [7:0] lsr_val = {2'b00, hold_empty, 5'h00}; // Flag for polling
    wire [7:0] rd_mux = (addr_i == uif_pkg::OFF_DATA) ? (dlab ? div_q[7:0] : 8'h00) :
                        (addr_i == uif_pkg::OFF_IER) ? (dlab ? div_q[15:8] : ier_q) :
                        (addr_i == uif_pkg::OFF_IIR) ? iir_val :
                        (addr_i == uif_pkg::OFF_LCR) ? lcr_q :
                        (addr_i == uif_pkg::OFF_LSR) ? lsr_val : 8'h00;

    // Baud divider next state
    wire bcnt_end = (bcnt_q == 16'h0001) || (bcnt_q == 16'h0000);
    wire tick_d = brun_q && (div_q != 16'h0000) && bcnt_end;

    // Transmit-empty set conditions
    wire ier_rise = wr_ier && new_tx_interrupt_enable_bit && !ier_q[uif_pkg::IER_THE];
    wire the_set_ier = ier_rise && hold_empty;
    wire si_done = si_arm_q && tick_q && (si_cnt_q == uif_pkg::SI_DELAY);
    wire the_set_drain = !si_arm_q && buf_out_valid && tx_ready_i && !wr_data &&
                         (buf_out_valid && !buf_in_ready ? 1'b0 : 1'b1);

    // Synchronisers for external cause levels
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            err_s_q <= 2'b00;
            rx_s_q <= 2'b00;
            ms_s_q <= 2'b00;
        end else begin
            err_s_q <= {err_s_q[0], line_err_i};
            rx_s_q <= {rx_s_q[0], rx_avail_i};
            ms_s_q <= {ms_s_q[0], modem_chg_i};
        end
    end

    // Control registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ier_q <= uif_pkg::IER_RST;
            lcr_q <= uif_pkg::LCR_RST;
            fifo_en_q <= 1'b0;
        end else begin
            if (wr_ier) begin
                ier_q <= {4'h0, wdata_i[3:0]}; // Zero write drops output
            end
            if (wr_lcr) begin
                lcr_q <= wdata_i;
            end
            if (wr_fcr) begin
                fifo_en_q <= wdata_i[uif_pkg::FCR_EN];
            end
        end
    end

    // Divisor latches and baud generator
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= uif_pkg::DIV_RST;
            brun_q <= !CMOS; // Stopped on CMOS builds until divisors rewritten
            bcnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            if (wr_dll) begin
                div_q[7:0] <= wdata_i;
            end
            if (wr_dlm) begin
                div_q[15:8] <= wdata_i;
            end
            if (wr_dll || wr_dlm) begin
                brun_q <= 1'b1; // Restart on divisor write
                bcnt_q <= 16'h0000;
            end else if (brun_q) begin
                bcnt_q <= bcnt_end ? div_q : bcnt_q - 16'h0001;
            end
            tick_q <= tick_d;
        end
    end

    // Transmit-empty interrupt with first-write delay
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            the_int_q <= 1'b1;
            si_arm_q <= 1'b0;
            si_cnt_q <= 6'h00;
            first_wr_q <= 1'b1;
        end else begin
            if (wr_data && first_wr_q && CMOS) begin
                si_arm_q <= 1'b1; // Start delay window
                si_cnt_q <= 6'h00;
                first_wr_q <= 1'b0;
            end else if (si_arm_q && tick_q) begin
                si_cnt_q <= si_cnt_q + 6'h01;
                if (si_done) begin
                    si_arm_q <= 1'b0;
                end
            end
            // Set wins over clear
            if (si_done || the_set_ier || the_set_drain) begin
                the_int_q <= 1'b1;
            end else if (wr_data || (rd_iir && id_code == uif_pkg::ID_THE)) begin
                the_int_q <= 1'b0; // Ident read clears
            end
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            rdata_q <= rd_i ? rd_mux : 8'h00;
            irq_q <= any_int;
        end
    end

    assign rdata_o = rdata_q;
    assign interrupt_out_o = irq_q;
    assign baud_tick_o = tick_q;

    // Transmit holding buffer
    uif_buf #(
        .WIDTH(8)
    ) u_buf (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_data),
        .in_ready_o(buf_in_ready),
        .in_data_i(wr_word.data),
        .out_valid_o(buf_out_valid),
        .out_ready_i(tx_ready_i),
        .out_data_o(buf_out_data)
    );
    assign tx_valid_o = buf_out_valid;
    assign tx_data_o = buf_out_data;
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, hold = 1'b0;
    logic line_err_i = 1'b0, rx_avail_i = 1'b0, modem_chg_i = 1'b0;
    logic tx_ready_i, tx_valid_o, baud_tick_o, interrupt_out_o;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, tx_data_o, v;
    logic [7:0] w [3];
    int n_mismatch = 0, check_count = 0, seed = 94, n, falls = 0;
    uif_core uif_core_i (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .line_err_i, .rx_avail_i, .modem_chg_i, .tx_ready_i, .tx_valid_o, .tx_data_o,
        .baud_tick_o, .interrupt_out_o);
    uif_sink uif_sink_i (.mclk_i, .hold_i(hold), .valid_i(tx_valid_o), .data_i(tx_data_o),
        .ready_o(tx_ready_i));
    // Clock and interrupt drop counter
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    always @(negedge interrupt_out_o) falls++;
    // Expected identification value
    function automatic logic [7:0] interrupt_ident_reg(input logic f, input logic [3:0] id);
        return {f, f, 2'b00, id};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic irq_is(input logic e);
        check("irq", {7'h00, interrupt_out_o}, {7'h00, e});
    endtask
    task automatic w_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic r_reg(input logic [2:0] a = uif_pkg::OFF_IIR);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        v = rdata_o;
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge mclk_i);
    endtask
    task automatic cause(input logic l, input logic r, input logic m);
        @(posedge mclk_i);
        line_err_i <= l;
        rx_avail_i <= r;
        modem_chg_i <= m;
        idle(5);
    endtask
    // Count baud ticks, optionally until the interrupt rises
    task automatic ticks(input int c, input bit stop);
        n = 0;
        for (int k = 0; k < c && !(stop && interrupt_out_o === 1'b1); k++) begin
            @(negedge mclk_i);
            n += int'(baud_tick_o);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        r_reg();
        check("iir reset", v, interrupt_ident_reg(1'b0, uif_pkg::ID_NONE));
        w_reg(uif_pkg::OFF_FCR, 8'h01);
        r_reg();
        check("iir fifo", v, interrupt_ident_reg(1'b1, uif_pkg::ID_NONE));
        ticks(40, 1'b0);
        check("ticks stopped", 8'(n), 8'h00);
        w_reg(uif_pkg::OFF_LCR, 8'h80);
        w_reg(uif_pkg::OFF_DATA, 8'h02);
        w_reg(uif_pkg::OFF_IER, 8'h00);
        w_reg(uif_pkg::OFF_LCR, 8'h00);
        ticks(40, 1'b0);
        check("ticks running", 8'(n), 8'(40 / 2));
        $display("ident and baud test done");
        w_reg(uif_pkg::OFF_IER, 8'h02);
        idle(2);
        irq_is(1'b1);
        r_reg();
        check("iir tx", v, interrupt_ident_reg(1'b1, uif_pkg::ID_THE));
        idle(2);
        irq_is(1'b0);
        w[0] = 8'($random(seed));
        w_reg(uif_pkg::OFF_DATA, w[0]);
        ticks(400, 1'b1);
        check("delay", {7'h00, n >= 16 && n <= 48}, 8'h01);
        check("word sent", uif_sink_i.got[0], w[0]);
        $display("tx interrupt test done");
        w_reg(uif_pkg::OFF_IER, 8'h0F);
        cause(1'b0, 1'b1, 1'b0);
        n = falls;
        r_reg();
        check("rx over tx", v, interrupt_ident_reg(1'b1, uif_pkg::ID_RDA));
        cause(1'b1, 1'b1, 1'b0);
        r_reg();
        check("line first", v, interrupt_ident_reg(1'b1, uif_pkg::ID_RLS));
        cause(1'b0, 1'b0, 1'b1);
        r_reg();
        check("tx next", v, interrupt_ident_reg(1'b1, uif_pkg::ID_THE));
        r_reg();
        check("modem last", v, interrupt_ident_reg(1'b1, uif_pkg::ID_MS));
        check("no drops", 8'(falls - n), 8'h00);
        w_reg(uif_pkg::OFF_IER, 8'h00);
        idle(2);
        irq_is(1'b0);
        w_reg(uif_pkg::OFF_IER, 8'h08);
        idle(2);
        irq_is(1'b1);
        cause(1'b0, 1'b0, 1'b0);
        w_reg(uif_pkg::OFF_IER, 8'h00);
        w_reg(uif_pkg::OFF_IER, 8'h02);
        idle(2);
        irq_is(1'b1);
        $display("priority test done");
        @(posedge mclk_i);
        hold <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            w[k] = 8'($random(seed));
            w_reg(uif_pkg::OFF_DATA, w[k]);
        end
        r_reg(uif_pkg::OFF_LSR);
        check("holding flag", {7'h00, v[uif_pkg::LSR_THE]}, 8'h00);
        @(posedge mclk_i);
        hold <= 1'b0;
        idle(8);
        check("words kept", 8'(uif_sink_i.got.size()), 8'h03);
        check("first kept", uif_sink_i.got[1], w[0]);
        check("second kept", uif_sink_i.got[2], w[1]);
        $display("buffer test done");
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        complete_run();
    end
endmodule
`default_nettype wire

// File: tb/uif_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module uif_monitor #(
    parameter bit CMOS = 1'b1,
    parameter bit FIFO_FIXED = 1'b1
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic line_err_i,
    input wire logic rx_avail_i,
    input wire logic modem_chg_i,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic baud_tick_o,
    input wire logic interrupt_out_o
);
    logic fen_q, wrote_q, dlab_q;
    logic [2:0] cause_q;
    // Access decode and falling cause detect
    wire logic iir_rd = rd_i && addr_i == uif_pkg::OFF_IIR;
    wire logic ier_clr = wr_i && addr_i == uif_pkg::OFF_IER && wdata_i == 8'h00 && !dlab_q;
    // Divisor latch write, either byte
    wire logic div_wr = wr_i && dlab_q && (addr_i == uif_pkg::OFF_DATA || addr_i == uif_pkg::OFF_IER);
    wire logic acc = wr_i || rd_i;
    wire logic cf = |(cause_q & ~{line_err_i, rx_avail_i, modem_chg_i});
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // Shadow of FIFO enable, DLAB, divisor write and cause levels
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fen_q <= 1'b0;
            wrote_q <= 1'b0;
            dlab_q <= 1'b0;
            cause_q <= 3'h0;
        end else begin
            fen_q <= (wr_i && addr_i == uif_pkg::OFF_FCR) ? wdata_i[uif_pkg::FCR_EN] : fen_q;
            dlab_q <= (wr_i && addr_i == uif_pkg::OFF_LCR) ? wdata_i[uif_pkg::LCR_DLAB] : dlab_q;
            wrote_q <= wrote_q || div_wr;
            cause_q <= {line_err_i, rx_avail_i, modem_chg_i};
        end
    end
    // Identification read that reports transmit empty
    sequence iir_the_s;
        iir_rd ##1 rdata_o[3:0] == uif_pkg::ID_THE;
    endsequence
    chk_fifo_on: assert property (iir_rd |=> rdata_o[7] == $past(fen_q))
        else $error("fifo enabled bit wrong");
    chk_fifo_kind: assert property (iir_rd |=> rdata_o[6] == (rdata_o[7] && FIFO_FIXED))
        else $error("fifo variant bit wrong");
    chk_baud_stopped: assert property (CMOS && !wrote_q |-> !baud_tick_o)
        else $error("baud tick before divisor write");
    chk_ier_zero: assert property (ier_clr |=> ##1 !interrupt_out_o)
        else $error("interrupt not dropped");
    chk_level_hold: assert property ($fell(interrupt_out_o) |-> $past(acc, 2) || $past(cf, 2) || $past(cf, 3) || $past(cf, 4))
        else $error("interrupt dropped without cause");
    chk_the_clear: assert property (iir_the_s ##1 iir_rd |=> rdata_o[3:0] != uif_pkg::ID_THE)
        else $error("transmit empty not cleared");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("stalled word changed");
endmodule
bind uif_core uif_monitor #(.CMOS(CMOS), .FIFO_FIXED(FIFO_FIXED)) uif_monitor_i (.*);
`default_nettype wire

// File: tb/uif_sink.sv
`timescale 1ns/100ps
`default_nettype none
module uif_sink (
    input wire logic mclk_i,
    input wire logic hold_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    output logic ready_o
);
    logic [7:0] got [$];
    // Stall while held, record each word taken
    assign ready_o = !hold_i;
    always @(posedge mclk_i) begin
        if (valid_i && ready_o) begin
            got.push_back(data_i);
        end
    end
endmodule
`default_nettype wire
